// ### src/cdic_pkg.sv
// Package for the clock divide and idle control block.
// Assumes a single 10 MHz system clock and an AXI4-Lite register master.
// Overview of operation
// R01 - With recovery enabled, any interrupt clears ratio enable, ratio back to 1:1.
// R02 - With recovery disabled, interrupts leave ratio enable and reduced ratio alone.
// R03 - CPU ratio field codes 0..7 divide by 1,2,4,...,128; reset value is 8.
// R04 - Ratio enable applies the field; clear forces 1:1.
// R05 - Fast RC postscale codes divide by 1..64, code 7 by 256.
// R06 - Clock divisor register resets only on power-on reset.
// R07 - Cold reset (power-on, brownout) loads clock source from startup select bits.
// R08 - Warm reset keeps current clock select at oscillator control bits 14:12.
// R09 - Device held in reset until supplies stable and clock ready.
// R10 - Crystal modes count 1024 oscillator periods before clock ready.
// R11 - With PLL enabled, also wait PLL lock time of 1.5 ms.
// R12 - In idle the CPU clock is gated and execution stops.
// R13 - Entering idle clears the watchdog count.
// R14 - In idle the system clock and enabled peripherals keep running.
// R15 - In idle low-power RC stays on if watchdog or clock monitor enabled.
// R16 - Idle ends on enabled interrupt, any reset, or watchdog time-out.
// R17 - On wake the CPU clock returns and execution resumes 2-4 cycles later.
// R18 - Interrupt during power-save instruction is deferred until entry, then wakes at once.
// R19 - Reduced ratio slows only the CPU clock; peripheral clock stays full rate.
// R20 - Ratio changes take effect only on a divided-clock boundary.
package cdic_pkg;
  localparam logic [31:0] CLK_HZ = 32'd10_000_000;
  // Register byte addresses
  localparam logic [3:0] ADDR_DIVISOR = 4'h0;
  localparam logic [3:0] ADDR_OSCCTL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Divisor register fields
  localparam int RECOVER_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int RATEN_BIT = 11;
  localparam int POSTSCALE_LSB = 8;
  localparam int POST_LSB = 6;
  localparam int PRE_LSB = 0;
  localparam logic [15:0] DIVISOR_RESET = 16'h3040;
  localparam logic [15:0] DIVISOR_MASK = 16'hFFDF;
  localparam int CUR_SEL_LSB = 12;
  // Start-up timing
  localparam int OST_CYCLES = 1024;
  localparam int LOCK_NS = 1_500_000;
  localparam int LOCK_CYCLES = LOCK_NS / (1_000_000_000 / 10_000_000);
  localparam int WAKE_CYCLES = 2;
  // Oscillator select code bit meaning crystal, and PLL
  localparam int SEL_XTAL_BIT = 1;
  localparam int SEL_PLL_BIT = 0;
  typedef enum {ST_RESET, ST_OST, ST_LOCK, ST_RUN, ST_IDLE, ST_WAKE} cdic_state_type;
  typedef struct packed {
    logic psave_req;
    logic irq;
    logic watchdog_timeout;
    logic watchdog_en;
    logic clock_monitor_en;
  } cdic_core_in_type;
  typedef struct packed {
    logic cpu_clk_en;
    logic cpu_reset;
    logic idle;
    logic watchdog_clear;
    logic low_power_rc_en;
    logic periph_clk_en;
    logic [7:0] postscale_div;
  } cdic_core_out_type;
endpackage

// ### src/cdic_top.sv
// Clock divide, start-up sequencing and idle control with AXI4-Lite registers.
// Assumes core inputs synchronous to aclk; oscillator clock treated as aclk.
`timescale 1ns/1ps
`default_nettype none
module cdic_top
  import cdic_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset causes and configuration
  input wire logic por,
  input wire logic brownout_reset,
  input wire logic warm_reset,
  input wire logic supply_ok,
  input wire logic [2:0] startup_clock_select,
  // Core events
  input wire cdic_core_in_type core_in,
  output cdic_core_out_type core_out,
  // AXI4-Lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  typedef struct packed {
    cdic_state_type st;
    logic [15:0] clock_divisor_reg;
    logic [2:0] current_clock_select;
    logic [20:0] cnt;
    logic [6:0] phase;
    logic [2:0] ratio_live;
    logic ratio_on_live;
    logic irq_held;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    cdic_core_out_type o;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cdic_regs_type;

  cdic_regs_type r;
  cdic_regs_type next_r;

  // Fast RC postscale code to divisor minus one
  function automatic logic [7:0] postscale_divisor(input logic [2:0] code);
    postscale_divisor = (code == 3'h7) ? 8'hFF : ((8'h01 << code) - 8'h01);
  endfunction

  // Ratio mask: one CPU clock enable every 2^code cycles
  // R03 divide by two to the code
  function automatic logic [6:0] ratio_mask(input logic [2:0] code);
    ratio_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // Merge write strobes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic boundary;
  logic wr_fire;
  logic cold;
  assign cold = por | brownout_reset;
  // R20 boundary detection
  assign boundary = ((r.phase & ratio_mask(r.ratio_live)) == 7'h00) | ~r.ratio_on_live;
  assign wr_fire = r.aw_got & r.w_got & ~r.bvalid;

  // Next-state logic
  always_comb
  begin
    next_r = r;
    next_r.o.watchdog_clear = 1'b0;
    next_r.awready = 1'b0;
    next_r.wready = 1'b0;
    next_r.arready = 1'b0;
    // R19 peripheral clock never divided
    next_r.o.periph_clk_en = 1'b1;
    next_r.phase = 7'(r.phase + 7'h01);
    // R20 ratio applied only on boundary
    if (boundary)
    begin
      next_r.ratio_live = r.clock_divisor_reg[RATIO_LSB +: 3];
      next_r.ratio_on_live = r.clock_divisor_reg[RATEN_BIT];
      next_r.phase = 7'h01;
    end
    // R05 fast RC postscale output
    next_r.o.postscale_div = postscale_divisor(r.clock_divisor_reg[POSTSCALE_LSB +: 3]);
    // AXI write channel capture
    if (s_awvalid & ~r.aw_got & ~r.awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_awaddr;
      next_r.awready = 1'b1;
    end
    if (s_wvalid & ~r.w_got & ~r.wready)
    begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_wdata;
      next_r.w_strb = s_wstrb;
      next_r.wready = 1'b1;
    end
    if (wr_fire)
    begin
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'h0;
      if (r.aw_addr == ADDR_DIVISOR)
        next_r.clock_divisor_reg = merge16(r.clock_divisor_reg, r.w_data, r.w_strb) & DIVISOR_MASK;
      else if (r.aw_addr != ADDR_OSCCTL && r.aw_addr != ADDR_STATUS)
        next_r.bresp = 2'h2;
    end
    if (r.bvalid & s_bready)
    begin
      next_r.bvalid = 1'b0;
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
    end
    // AXI read channel
    if (s_arvalid & ~r.rvalid & ~r.arready)
    begin
      next_r.arready = 1'b1;
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'h0;
      unique case (s_araddr)
        ADDR_DIVISOR: next_r.rdata = {16'h0000, r.clock_divisor_reg};
        ADDR_OSCCTL: next_r.rdata = {17'h00000, r.current_clock_select, 12'h000};
        ADDR_STATUS: next_r.rdata = {29'h00000000, r.o.idle, r.o.cpu_reset, r.ratio_on_live};
        default:
        begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = 2'h2;
        end
      endcase
    end
    if (r.rvalid & s_rready)
      next_r.rvalid = 1'b0;
    // R01 recover on interrupt clears ratio enable; R02 otherwise untouched
    if (core_in.irq & r.clock_divisor_reg[RECOVER_BIT])
      next_r.clock_divisor_reg[RATEN_BIT] = 1'b0;
    // CPU clock enable from live ratio
    // R04 ratio forced to 1:1 when disabled
    next_r.o.cpu_clk_en = (~r.ratio_on_live | ((r.phase & ratio_mask(r.ratio_live)) == 7'h00));
    // R15 low-power RC kept for watchdog or monitor
    next_r.o.low_power_rc_en = core_in.watchdog_en | core_in.clock_monitor_en;
    unique case (r.st)
      ST_RESET:
      begin
        next_r.o.cpu_reset = 1'b1;
        next_r.cnt = '0;
        // R09 wait for supplies
        if (supply_ok)
          next_r.st = r.current_clock_select[SEL_XTAL_BIT] ? ST_OST
                    : (r.current_clock_select[SEL_PLL_BIT] ? ST_LOCK : ST_RUN);
      end
      ST_OST:
      begin
        next_r.cnt = 21'(r.cnt + 21'h1);
        // R10 oscillator start-up timer
        if (r.cnt == 21'(OST_CYCLES - 1))
        begin
          next_r.cnt = '0;
          next_r.st = r.current_clock_select[SEL_PLL_BIT] ? ST_LOCK : ST_RUN;
        end
      end
      ST_LOCK:
      begin
        next_r.cnt = 21'(r.cnt + 21'h1);
        // R11 PLL lock wait after start-up
        if (r.cnt == 21'(LOCK_COUNT - 1))
          next_r.st = ST_RUN;
      end
      ST_RUN:
      begin
        next_r.o.cpu_reset = 1'b0;
        next_r.o.idle = 1'b0;
        // R18 interrupt during power-save held until idle entry
        if (core_in.psave_req)
        begin
          next_r.st = ST_IDLE;
          next_r.o.idle = 1'b1;
          next_r.irq_held = core_in.irq;
          // R13 watchdog cleared on entry
          next_r.o.watchdog_clear = 1'b1;
        end
      end
      ST_IDLE:
      begin
        // R16 wake on interrupt or watchdog; R18 deferred interrupt wakes at once
        if (core_in.irq | core_in.watchdog_timeout | r.irq_held)
        begin
          next_r.st = ST_WAKE;
          next_r.irq_held = 1'b0;
          next_r.cnt = '0;
        end
      end
      ST_WAKE:
      begin
        next_r.cnt = 21'(r.cnt + 21'h1);
        // R17 resume after wake delay
        if (r.cnt == 21'(WAKE_CYCLES - 1))
        begin
          next_r.st = ST_RUN;
          next_r.o.idle = 1'b0;
        end
      end
    endcase
    // R12 CPU clock gated in idle; R14 peripherals keep running
    if (next_r.o.idle | next_r.o.cpu_reset)
      next_r.o.cpu_clk_en = 1'b0;
    // R08 warm reset keeps clock select; R06 divisor untouched
    if (warm_reset & ~cold)
    begin
      next_r.st = ST_RESET;
      next_r.o.cpu_reset = 1'b1;
      next_r.o.idle = 1'b0;
    end
    // R07 cold reset loads startup select; R06 divisor reset on power-on only
    if (cold)
    begin
      next_r.st = ST_RESET;
      next_r.o.cpu_reset = 1'b1;
      next_r.o.idle = 1'b0;
      next_r.current_clock_select = startup_clock_select;
      if (por)
        next_r.clock_divisor_reg = DIVISOR_RESET;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.st <= ST_RESET;
      r.clock_divisor_reg <= DIVISOR_RESET;
      r.o.cpu_reset <= 1'b1;
      r.o.periph_clk_en <= 1'b1;
      r.o.postscale_div <= 8'h00;
    end
    else
      r <= next_r;
  end

  assign core_out = r.o;
  assign s_awready = r.awready;
  assign s_wready = r.wready;
  assign s_bvalid = r.bvalid;
  assign s_bresp = r.bresp;
  assign s_arready = r.arready;
  assign s_rvalid = r.rvalid;
  assign s_rresp = r.rresp;
  assign s_rdata = r.rdata;

  // R01 recovery clears enable one cycle later
  AST_RECOVER_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    core_in.irq && r.clock_divisor_reg[RECOVER_BIT] && !cold && !wr_fire |=> !r.clock_divisor_reg[RATEN_BIT])
    else $error("recover on interrupt did not clear ratio enable");
  // R02 no recovery keeps enable
  AST_NO_RECOVER_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    core_in.irq && !r.clock_divisor_reg[RECOVER_BIT] && !cold && !wr_fire && r.clock_divisor_reg[RATEN_BIT]
    |=> r.clock_divisor_reg[RATEN_BIT])
    else $error("interrupt changed ratio enable without recovery");
  // R04 full rate when ratio disabled
  AST_ONE_TO_ONE: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    r.st == ST_RUN && !r.ratio_on_live && !core_in.psave_req && !cold && !warm_reset |=> core_out.cpu_clk_en)
    else $error("cpu clock not full rate with ratio disabled");
  // R06 warm reset leaves divisor alone
  AST_WARM_KEEP: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    warm_reset && !cold && !wr_fire && !core_in.irq |=> $stable(r.clock_divisor_reg))
    else $error("warm reset changed divisor");
  // R07 cold reset loads startup select
  AST_COLD_SEL: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    cold |=> r.current_clock_select == $past(startup_clock_select))
    else $error("cold reset did not load startup select");
  // R10 reset held through the first 8 cycles of the start-up timer
  sequence s_ost_start;
    r.st == ST_RESET && supply_ok && r.current_clock_select[SEL_XTAL_BIT] && !cold && !warm_reset;
  endsequence
  AST_OST_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    s_ost_start |=> core_out.cpu_reset [*8])
    else $error("start-up timer released too early");
  // R13 watchdog cleared on idle entry
  AST_WATCHDOG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    $rose(core_out.idle) |-> core_out.watchdog_clear)
    else $error("watchdog not cleared on idle entry");
  // R12 cpu clock gated in idle
  AST_IDLE_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    core_out.idle |-> !core_out.cpu_clk_en)
    else $error("cpu clock running in idle");
  // R17 wake resumes within bound
  sequence s_wake;
    r.st == ST_IDLE && core_in.irq && !cold && !warm_reset;
  endsequence
  AST_WAKE_TIME: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    s_wake |-> ##[2:4] !core_out.idle)
    else $error("wake from idle outside 2-4 cycles");
  // R10 no early exit from the start-up timer
  AST_OST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    r.st == ST_OST && r.cnt != 21'(OST_CYCLES - 1) && !cold && !warm_reset |=> r.st == ST_OST)
    else $error("start-up timer left before its full count");
  // R15 low-power RC follows its users
  AST_RC_KEPT: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    core_in.watchdog_en || core_in.clock_monitor_en |=> core_out.low_power_rc_en)
    else $error("low-power RC off while watchdog or monitor enabled");
  // R16 watchdog time-out ends idle
  AST_TIMEOUT_WAKE: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    r.st == ST_IDLE && core_in.watchdog_timeout && !cold && !warm_reset |=> r.st == ST_WAKE)
    else $error("watchdog time-out did not end idle");
  // R18 deferred interrupt wakes at once
  AST_DEFER_WAKE: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    r.st == ST_IDLE && r.irq_held && !cold && !warm_reset |=> r.st == ST_WAKE)
    else $error("deferred interrupt did not wake from idle");
  // R20 live ratio moves only on a boundary
  AST_RATIO_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    !boundary |=> $stable(r.ratio_live) && $stable(r.ratio_on_live))
    else $error("live ratio changed off a divided-clock boundary");
endmodule // cdic_top
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the clock divide and idle control block.
// Assumes the design's own assertions; bench drives AXI4-Lite and core events.
`timescale 1ns/1ps
`default_nettype none
module tb
  import cdic_pkg::*;
;
  // Stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por = 1'b1;
  logic brownout_reset = 1'b0;
  logic warm_reset = 1'b0;
  logic supply_ok = 1'b0;
  logic [2:0] sel = 3'h3;
  cdic_core_in_type core_in = '0;
  cdic_core_out_type core_out;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hF;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd_val;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, resp;
  int num_errors = 0;
  int tests_run = 0;
  int n;

  // Short lock count keeps the start-up wait brief
  cdic_top #(.LOCK_COUNT(20)) u_cdic_top (
    .aclk(aclk), .aresetn(aresetn), .por(por), .brownout_reset(brownout_reset),
    .warm_reset(warm_reset), .supply_ok(supply_ok), .startup_clock_select(sel),
    .core_in(core_in), .core_out(core_out),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
  );

  // 100 ns period
  always #50 aclk = ~aclk;

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A wait that ran out counts as a mismatch
  task automatic stop;
    num_errors++;
    test_done;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    k = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
      k++;
    end
    while (s_bvalid !== 1'b1 && k < 50);
    if (k >= 50) stop;
    s_bready <= 1'b0;
    r = s_bresp;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    k = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
      k++;
    end
    while (s_rvalid !== 1'b1 && k < 50);
    if (k >= 50) stop;
    s_rready <= 1'b0;
    d = s_rdata;
    r = s_rresp;
  endtask

  // Edges until the core leaves reset
  task automatic run_wait;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (core_out.cpu_reset !== 1'b0 && n < 3000);
    if (n >= 3000) stop;
  endtask

  // Reset cause held 20 cycles; bus reset stays released so the block sees it
  task automatic rst(input logic p, input logic b, input logic w);
    @(posedge aclk);
    por <= p;
    brownout_reset <= b;
    warm_reset <= w;
    repeat (20) @(posedge aclk);
    por <= 1'b0;
    brownout_reset <= 1'b0;
    warm_reset <= 1'b0;
    run_wait;
  endtask

  // CPU enables in 128 cycles, after a settle longer than any divided period
  task automatic cnt_en(output int c);
    repeat (300) @(posedge aclk);
    c = 0;
    repeat (128)
    begin
      @(posedge aclk);
      if (core_out.cpu_clk_en === 1'b1) c++;
    end
  endtask

  task automatic pulse_irq;
    @(posedge aclk);
    core_in.irq <= 1'b1;
    repeat (3) @(posedge aclk);
    core_in.irq <= 1'b0;
  endtask

  // Idle entry, then wake by interrupt (0), time-out (1) or coincident interrupt (2)
  task automatic idle_run(input int h);
    @(posedge aclk);
    core_in.psave_req <= 1'b1;
    core_in.irq <= (h == 2);
    @(posedge aclk);
    core_in.psave_req <= 1'b0;
    core_in.irq <= 1'b0;
    @(posedge aclk);
    chk({core_out.idle, core_out.cpu_clk_en, core_out.watchdog_clear}, 3'h5);
    chk({core_out.low_power_rc_en, core_out.periph_clk_en}, 2'h3);
    // Coincident case gets no second interrupt: only the held one can wake it
    core_in.irq <= (h == 0);
    core_in.watchdog_timeout <= (h == 1);
    n = 0;
    do
    begin
      @(posedge aclk);
      core_in.watchdog_timeout <= 1'b0;
      n++;
    end
    while (core_out.idle !== 1'b0 && n < 20);
    if (n >= 20) stop;
    core_in.irq <= 1'b0;
    chk(n >= 2 && n <= 5, 1'b1);
    $display("test idle wake %0d done", h);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Power-on cause seen for one edge after the bus reset lifts
    @(posedge aclk);
    por <= 1'b0;
    repeat (100) @(posedge aclk);
    chk(core_out.cpu_reset, 1'b1);
    supply_ok <= 1'b1;
    run_wait;
    chk(n >= 1044 && n <= 1100, 1'b1);
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h3040);
    rd(4'h4, rd_val, resp);
    chk(rd_val[14:12], 3'h3);
    $display("test startup done");
    // Unmapped place and read-only oscillator control
    rd(4'hC, rd_val, resp);
    chk(rd_val, 32'h0);
    chk(resp, 2'h2);
    wr(4'hC, 32'h1, resp);
    chk(resp, 2'h2);
    wr(4'h4, 32'h0, resp);
    rd(4'h4, rd_val, resp);
    chk(rd_val[14:12], 3'h3);
    $display("test map done");
    // Every ratio and postscale code
    for (int k = 0; k < 8; k++)
    begin
      wr(4'h0, (k << 12) | (k << 8) | 32'h800, resp);
      rd(4'h0, rd_val, resp);
      chk(rd_val, (k << 12) | (k << 8) | 32'h800);
      chk(core_out.postscale_div, (k == 7) ? 255 : (1 << k) - 1);
      cnt_en(n);
      chk(n, 128 >> k);
    end
    wr(4'h0, 32'h7000, resp);
    cnt_en(n);
    chk(n, 128);
    chk(core_out.periph_clk_en, 1'b1);
    $display("test ratio done");
    // Interrupt with and without recovery
    wr(4'h0, 32'h9800, resp);
    pulse_irq;
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h9000);
    cnt_en(n);
    chk(n, 128);
    wr(4'h0, 32'h1800, resp);
    pulse_irq;
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h1800);
    cnt_en(n);
    chk(n, 64);
    $display("test recovery done");
    core_in.watchdog_en <= 1'b1;
    for (int h = 0; h < 3; h++)
      idle_run(h);
    // Reset kinds against divisor and clock source
    sel <= 3'h0;
    rst(1'b0, 1'b0, 1'b1);
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h1800);
    rd(4'h4, rd_val, resp);
    chk(rd_val[14:12], 3'h3);
    rst(1'b0, 1'b1, 1'b0);
    rd(4'h4, rd_val, resp);
    chk(rd_val[14:12], 3'h0);
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h1800);
    rst(1'b1, 1'b0, 1'b0);
    rd(4'h0, rd_val, resp);
    chk(rd_val, 32'h3040);
    $display("test resets done");
    test_done;
  end
endmodule // tb
`default_nettype wire
